// ==== fpf_expr_eval.sv ====
// Postfix evaluator: one program step per clock over a one-bit stack.
// Assumes the program is well formed and closed by an end step.
module fpf_expr_eval
    import fpf_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           start,
    input  wire logic [fpf_pkg::NUM_TERMS-1:0]  termVec,
    input  fpf_pkg::fpf_op_t                    progOp [fpf_pkg::PROG_LEN],
    input  wire logic [fpf_pkg::TERM_IDX_W-1:0] progArg [fpf_pkg::PROG_LEN],
    output logic                                busy,
    output logic                                resultValid,
    output logic                                result
);

    logic [STACK_DEPTH-1:0] stackReg;
    logic [PROG_IDX_W-1:0]  pcReg;
    logic                   runReg;
    fpf_op_t                curOp;
    logic                   atEnd;

    assign curOp = progOp[pcReg];
    assign atEnd = (curOp == OP_END) || (pcReg == PROG_IDX_W'(PROG_LEN - 1));
    assign busy  = runReg;

    // =================================================================
    // sequencing
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            runReg      <= 1'b0;
            pcReg       <= '0;
            resultValid <= 1'b0;
            result      <= 1'b0;
        end
        else
        begin
            resultValid <= 1'b0;
            if (start)
            begin
                runReg <= 1'b1;
                pcReg  <= '0;
            end
            else if (runReg)
            begin
                if (atEnd)
                begin
                    runReg      <= 1'b0;
                    resultValid <= 1'b1;
                    result      <= stackReg[0];
                end
                else
                begin
                    pcReg <= PROG_IDX_W'(pcReg + 1);
                end
            end
        end
    end

    // =================================================================
    // stack; groups are already flattened into postfix order
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stackReg <= '0;
        end
        else if (start)
        begin
            stackReg <= '0;
        end
        else if (runReg && !atEnd)
        begin
            case (curOp)
                OP_TERM: stackReg <= {stackReg[STACK_DEPTH-2:0], termVec[progArg[pcReg]]};
                OP_AND:  stackReg <= {1'b0, stackReg[STACK_DEPTH-1:2],
                                      stackReg[0] & stackReg[1]};
                OP_OR:   stackReg <= {1'b0, stackReg[STACK_DEPTH-1:2],
                                      stackReg[0] | stackReg[1]};
                OP_NOT:  stackReg <= {stackReg[STACK_DEPTH-1:1], ~stackReg[0]};
                default: stackReg <= stackReg;
            endcase
        end
    end

endmodule

// ==== fpf_frame_filter.sv ====
// Frame pattern filter top: holds the loaded expression, walks received frames
// and gives a discard or forward verdict after each frame's last byte.
// Assumes the receive path holds the next frame while rxReady is low and does
// not forward a frame before its verdict is out.
module fpf_frame_filter
    import fpf_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           filterEnable,
    input  wire logic                           cfgTermWr,
    input  wire logic [fpf_pkg::TERM_IDX_W-1:0] cfgTermIdx,
    input  wire logic [fpf_pkg::OFF_W-1:0]      cfgTermOffset,
    input  wire logic [fpf_pkg::LEN_W-1:0]      cfgTermLen,
    input  wire logic [fpf_pkg::VAL_W-1:0]      cfgTermValue,
    input  wire logic [fpf_pkg::VAL_W-1:0]      cfgTermCare,
    input  wire logic                           cfgProgWr,
    input  wire logic [fpf_pkg::PROG_IDX_W-1:0] cfgProgIdx,
    input  fpf_pkg::fpf_op_t                    cfgProgOp,
    input  wire logic [fpf_pkg::TERM_IDX_W-1:0] cfgProgArg,
    output logic                                cfgRefused,
    input  wire logic                           rxValid,
    output logic                                rxReady,
    input  wire logic                           rxFirst,
    input  wire logic                           rxLast,
    input  wire logic [7:0]                     rxData,
    output logic                                decisionValid,
    output logic                                decisionDiscard
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RECV,
        ST_EVAL
    } fpf_state_t;

    fpf_state_t             stateReg;
    fpf_state_t             stateNext;
    logic [OFF_W-1:0]       termOffsetReg [NUM_TERMS];
    logic [LEN_W-1:0]       termLenReg    [NUM_TERMS];
    logic [VAL_W-1:0]       termValueReg  [NUM_TERMS];
    logic [VAL_W-1:0]       termCareReg   [NUM_TERMS];
    fpf_op_t                progOpReg     [PROG_LEN];
    logic [TERM_IDX_W-1:0]  progArgReg    [PROG_LEN];
    logic [OFF_W-1:0]       posReg;
    logic [OFF_W-1:0]       curPos;
    logic [NUM_TERMS-1:0]   termVec;
    logic                   accept;
    logic                   frameStart;
    logic                   frameEnd;
    logic                   evalStartReg;
    logic                   evalBusy;
    logic                   evalDone;
    logic                   evalResult;
    logic [PROG_IDX_W:0]    notCount;
    logic                   refuseNow;

    // counts NOT steps in the loaded program
    function automatic logic [PROG_IDX_W:0] countNots(input fpf_op_t ops [PROG_LEN]);
        logic [PROG_IDX_W:0] n;
        n = '0;
        for (int k = 0; k < PROG_LEN; k++)
        begin
            if (ops[k] == OP_NOT)
            begin
                n = (PROG_IDX_W+1)'(n + 1);
            end
        end
        return n;
    endfunction

    // =================================================================
    // expression storage
    assign notCount  = countNots(progOpReg);
    assign refuseNow = cfgProgWr && (cfgProgOp == OP_NOT) && (notCount != '0) &&
                       (progOpReg[cfgProgIdx] != OP_NOT);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int k = 0; k < NUM_TERMS; k++)
            begin
                termOffsetReg[k] <= '0;
                termLenReg[k]    <= TERM_LEN_RST;
                termValueReg[k]  <= TERM_VAL_RST;
                termCareReg[k]   <= TERM_VAL_RST;
            end
        end
        else if (cfgTermWr)
        begin
            // offset and pattern arrive already split at the separator
            termOffsetReg[cfgTermIdx] <= cfgTermOffset;
            termLenReg[cfgTermIdx]    <= cfgTermLen;
            termValueReg[cfgTermIdx]  <= cfgTermValue;
            termCareReg[cfgTermIdx]   <= cfgTermCare;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int k = 0; k < PROG_LEN; k++)
            begin
                progOpReg[k]  <= OP_END;
                progArgReg[k] <= '0;
            end
        end
        else if (cfgProgWr && !refuseNow)
        begin
            progOpReg[cfgProgIdx]  <= cfgProgOp;
            progArgReg[cfgProgIdx] <= cfgProgArg;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cfgRefused <= 1'b0;
        end
        else
        begin
            cfgRefused <= refuseNow;
        end
    end

    // =================================================================
    // frame walk
    assign rxReady    = (stateReg != ST_EVAL);
    assign accept     = rxValid && rxReady && (stateReg == ST_RECV || rxFirst);
    assign frameStart = accept && (stateReg == ST_IDLE || rxFirst);
    assign frameEnd   = accept && rxLast;
    assign curPos     = frameStart ? '0 : posReg;

    always_comb
    begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE: if (frameStart) stateNext = rxLast ? ST_EVAL : ST_RECV;
            ST_RECV: if (frameEnd) stateNext = ST_EVAL;
            ST_EVAL: if (evalDone) stateNext = ST_IDLE;
            default: stateNext = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stateReg <= ST_IDLE;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            posReg <= '0;
        end
        else if (accept)
        begin
            posReg <= (curPos == POS_MAX) ? POS_MAX : OFF_W'(curPos + 1);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            evalStartReg <= 1'b0;
        end
        else
        begin
            evalStartReg <= frameEnd;
        end
    end

    // =================================================================
    // term matchers and evaluator
    for (genvar g = 0; g < NUM_TERMS; g++)
    begin : gTerm
        fpf_term_match uTerm (
            .clock      (clock),
            .rst        (rst),
            .frameStart (frameStart),
            .byteValid  (accept),
            .bytePos    (curPos),
            .byteData   (rxData),
            .termOffset (termOffsetReg[g]),
            .termLen    (termLenReg[g]),
            .termValue  (termValueReg[g]),
            .termCare   (termCareReg[g]),
            .termTrue   (termVec[g])
        );
    end

    fpf_expr_eval uEval (
        .clock       (clock),
        .rst         (rst),
        .start       (evalStartReg),
        .termVec     (termVec),
        .progOp      (progOpReg),
        .progArg     (progArgReg),
        .busy        (evalBusy),
        .resultValid (evalDone),
        .result      (evalResult)
    );

    // =================================================================
    // verdict
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            decisionValid   <= 1'b0;
            decisionDiscard <= 1'b0;
        end
        else
        begin
            decisionValid   <= evalDone;
            decisionDiscard <= evalDone && filterEnable && evalResult;
        end
    end

    // =================================================================
    // checks
    sequence frameEndSeq;
        rxValid && rxReady && rxLast && (stateReg == ST_RECV || rxFirst);
    endsequence

    sequence firstByteSeq;
        rxValid && rxFirst && rxReady;
    endsequence

    AST_DECIDE_BOUNDED: assert property (@(posedge clock) disable iff (rst)
        frameEndSeq |-> ##[3:18] decisionValid)
        else $error("no verdict within bound after frame end");

    AST_HOLD_DURING_EVAL: assert property (@(posedge clock) disable iff (rst)
        (evalStartReg || evalBusy || evalDone) |-> !rxReady)
        else $error("receive path not held during evaluation");

    AST_EVAL_STARTS: assert property (@(posedge clock) disable iff (rst)
        frameEndSeq |=> evalStartReg ##1 evalBusy)
        else $error("evaluation not started after frame end");

    AST_DISCARD_QUALIFIED: assert property (@(posedge clock) disable iff (rst)
        !decisionValid |-> !decisionDiscard)
        else $error("discard shown without verdict");

    AST_DISCARD_FOLLOWS: assert property (@(posedge clock) disable iff (rst)
        evalDone |=> decisionValid &&
                     (decisionDiscard == ($past(filterEnable) && $past(evalResult))))
        else $error("verdict does not follow expression");

    AST_SINGLE_NOT: assert property (@(posedge clock) disable iff (rst)
        notCount <= (PROG_IDX_W+1)'(1))
        else $error("more than one NOT loaded");

    AST_NOT_REFUSED: assert property (@(posedge clock) disable iff (rst)
        cfgProgWr && cfgProgOp == OP_NOT && notCount == (PROG_IDX_W+1)'(1) &&
        progOpReg[cfgProgIdx] != OP_NOT |=> cfgRefused && $stable(notCount))
        else $error("second NOT not refused");

    AST_POS_FROM_ZERO: assert property (@(posedge clock) disable iff (rst)
        firstByteSeq ##1 (rxValid && rxReady && !rxFirst) |=> posReg == OFF_W'(2))
        else $error("byte position not counted from zero");

    AST_NO_VERDICT_RECV: assert property (@(posedge clock) disable iff (rst)
        stateReg == ST_RECV |-> !decisionValid && !evalBusy)
        else $error("verdict while frame still arriving");

endmodule

// ==== fpf_pkg.sv ====
// Constants, types and timing figures shared by the frame pattern filter.
// Assumes one 20 MHz clock; the filter expression arrives already compiled
// into a term table plus a postfix program from the management side.
// =====================================================================
// Overview of operation
// - term true when frame bytes equal value
// - offsets count from frame byte zero
// - comparison values held as hex nibbles
// - offset and pattern loaded as separate fields
// - OR true when any operand true
// - AND true only when all true
// - NOT term true when data differs
// - bracketed groups evaluated first via postfix
// - true expression discards the frame
// - NOT on whole expression inverts discard
// - only one NOT operator loadable
// - X nibble is a whole-nibble don't care
// - type field octets twelve and thirteen
// - transport byte sits at octet twenty-three
// - NOT allowed on group inside AND
// - quoted nibble gives per-bit don't cares
package fpf_pkg;

    // =================================================================
    // sizes
    localparam int NUM_TERMS   = 8;
    localparam int TERM_IDX_W  = 3;
    localparam int NIB_MAX     = 16;
    localparam int VAL_W       = 4 * NIB_MAX;
    localparam int OFF_W       = 11;
    localparam int LEN_W       = 5;
    localparam int PROG_LEN    = 16;
    localparam int PROG_IDX_W  = 4;
    localparam int STACK_DEPTH = 8;

    // =================================================================
    // well-known field positions
    localparam logic [OFF_W-1:0] PROTO_TYPE_OFFSET = 11'h00C;
    localparam logic [LEN_W-1:0] PROTO_TYPE_NIBS   = 5'h04;
    localparam logic [OFF_W-1:0] TRANSPORT_OFFSET  = 11'h017;
    localparam logic [7:0]       TRANSPORT_CONN    = 8'h06;

    // =================================================================
    // reset values and timing
    localparam logic [OFF_W-1:0] POS_MAX        = 11'h7FF;
    localparam logic [LEN_W-1:0] TERM_LEN_RST   = 5'h00;
    localparam logic [VAL_W-1:0] TERM_VAL_RST   = 64'h0;
    localparam int               CLOCK_HZ       = 20_000_000;
    localparam int               DECIDE_MAX_CYC = PROG_LEN + 3;

    typedef enum logic [2:0] {
        OP_TERM,
        OP_AND,
        OP_OR,
        OP_NOT,
        OP_END
    } fpf_op_t;

endpackage

// ==== fpf_rx_source.sv ====
// Receive path model: presents one stored frame byte by byte to the filter.
// Assumes send is entered 2 ns after a rising clock edge and that the
// caller fills fr before each frame.
module fpf_rx_source
(
    input  wire logic       clock,
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic            rxFirst,
    output logic            rxLast,
    output logic [7:0]      rxData
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] fr [64];

    initial
    begin
        rxValid = 1'b0;
        rxFirst = 1'b0;
        rxLast  = 1'b0;
        rxData  = 8'hA5;
    end

    // =================================================================
    // frame transfer: each byte held until an edge sees rxReady high
    task automatic send(input int n);
        for (int i = 0; i < n; i++)
        begin
            rxValid = 1'b1;
            rxFirst = (i == 0);
            rxLast  = (i == n - 1);
            rxData  = fr[i];
            do @(posedge clock); while (rxReady !== 1'b1);
            #2;
        end
        rxValid = 1'b0;
        rxFirst = 1'b0;
        rxLast  = 1'b0;
        // released data never repeats the last byte
        rxData  = ~rxData;
    endtask
endmodule

// ==== fpf_term_match.sv ====
// One filter term: compares the nibbles of its window as frame bytes stream by.
// Assumes bytePos counts from zero at the first byte, marked by frameStart.
module fpf_term_match
    import fpf_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      frameStart,
    input  wire logic                      byteValid,
    input  wire logic [fpf_pkg::OFF_W-1:0] bytePos,
    input  wire logic [7:0]                byteData,
    input  wire logic [fpf_pkg::OFF_W-1:0] termOffset,
    input  wire logic [fpf_pkg::LEN_W-1:0] termLen,
    input  wire logic [fpf_pkg::VAL_W-1:0] termValue,
    input  wire logic [fpf_pkg::VAL_W-1:0] termCare,
    output logic                           termTrue
);

    logic [OFF_W-1:0] rel;
    logic [OFF_W:0]   hiIdx;
    logic [OFF_W:0]   loIdx;
    logic [OFF_W:0]   lenExt;
    logic             inWin;
    logic             loUsed;
    logic             lastByte;
    logic             byteOk;
    logic             matchReg;
    logic             doneReg;

    // masked nibble compare; care bit low means don't care
    function automatic logic nibOk(input logic [3:0] d, input logic [VAL_W-1:0] v,
                                   input logic [VAL_W-1:0] c, input logic [3:0] i);
        logic [3:0] vv;
        logic [3:0] cc;
        vv = v[(VAL_W-1) - 4*i -: 4];
        cc = c[(VAL_W-1) - 4*i -: 4];
        return ((d ^ vv) & cc) == 4'h0;
    endfunction

    // =================================================================
    // window position
    assign rel      = bytePos - termOffset;
    assign hiIdx    = {rel, 1'b0};
    assign loIdx    = (OFF_W+1)'(hiIdx + 1);
    assign lenExt   = (OFF_W+1)'(termLen);
    assign inWin    = (bytePos >= termOffset) && (hiIdx < lenExt);
    assign loUsed   = loIdx < lenExt;
    assign lastByte = (OFF_W+1)'(hiIdx + 2) >= lenExt;
    assign byteOk   = nibOk(byteData[7:4], termValue, termCare, hiIdx[3:0]) &&
                      (!loUsed || nibOk(byteData[3:0], termValue, termCare,
                                        loIdx[3:0]));

    // =================================================================
    // running match state
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            matchReg <= 1'b0;
            doneReg  <= 1'b0;
        end
        else if (byteValid)
        begin
            matchReg <= (frameStart | matchReg) & (!inWin | byteOk);
            doneReg  <= (!frameStart & doneReg) | (inWin & lastByte);
        end
    end

    // a window not fully received stays false
    assign termTrue = matchReg & doneReg;

endmodule

// ==== tb.sv ====
// Self-checking bench for the frame pattern filter top.
// Assumes the receive path model fpf_rx_source and the fpf_pkg package.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fpf_pkg::*;

    logic                  clock;
    logic                  rst;
    logic                  filterEnable;
    logic                  cfgTermWr;
    logic [TERM_IDX_W-1:0] cfgTermIdx;
    logic [OFF_W-1:0]      cfgTermOffset;
    logic [LEN_W-1:0]      cfgTermLen;
    logic [VAL_W-1:0]      cfgTermValue;
    logic [VAL_W-1:0]      cfgTermCare;
    logic                  cfgProgWr;
    logic [PROG_IDX_W-1:0] cfgProgIdx;
    fpf_op_t               cfgProgOp;
    logic [TERM_IDX_W-1:0] cfgProgArg;
    logic                  cfgRefused;
    logic                  rxValid;
    logic                  rxReady;
    logic                  rxFirst;
    logic                  rxLast;
    logic [7:0]            rxData;
    logic                  decisionValid;
    logic                  decisionDiscard;
    int                    fail_count;
    int                    total_checks;
    logic                  progRefused;

    fpf_frame_filter dut (.clock(clock), .rst(rst), .filterEnable(filterEnable),
        .cfgTermWr(cfgTermWr), .cfgTermIdx(cfgTermIdx), .cfgTermOffset(cfgTermOffset),
        .cfgTermLen(cfgTermLen), .cfgTermValue(cfgTermValue), .cfgTermCare(cfgTermCare),
        .cfgProgWr(cfgProgWr), .cfgProgIdx(cfgProgIdx), .cfgProgOp(cfgProgOp),
        .cfgProgArg(cfgProgArg), .cfgRefused(cfgRefused), .rxValid(rxValid),
        .rxReady(rxReady), .rxFirst(rxFirst), .rxLast(rxLast), .rxData(rxData),
        .decisionValid(decisionValid), .decisionDiscard(decisionDiscard));

    fpf_rx_source src (.clock(clock), .rxReady(rxReady), .rxValid(rxValid),
        .rxFirst(rxFirst), .rxLast(rxLast), .rxData(rxData));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // =================================================================
    // reporting
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // =================================================================
    // drivers, all entered 2 ns after an edge
    task automatic term(input int idx, input logic [10:0] off, input logic [4:0] len,
                        input logic [63:0] val, input logic [63:0] care);
        cfgTermIdx    = 3'(idx);
        cfgTermOffset = off;
        cfgTermLen    = len;
        cfgTermValue  = val;
        cfgTermCare   = care;
        cfgTermWr     = 1'b1;
        @(posedge clock);
        #2 cfgTermWr  = 1'b0;
        // one idle edge so back-to-back writes never re-raise the strobe at once
        @(posedge clock);
        #2;
    endtask

    task automatic progW(input int idx, input fpf_op_t op, input int arg);
        cfgProgIdx = 4'(idx);
        cfgProgOp  = op;
        cfgProgArg = 3'(arg);
        cfgProgWr  = 1'b1;
        @(posedge clock);
        #2 cfgProgWr = 1'b0;
        // refusal pulse stands only in the cycle after the write
        progRefused = cfgRefused;
        @(posedge clock);
        #2;
    endtask

    // letters a..h push a term slot; & | ~ are operators; end step follows
    task automatic loadProg(input string s);
        for (int i = 0; i < 16; i++) progW(i, OP_END, 0);
        for (int i = 0; i < s.len(); i++)
        begin
            case (s[i])
                "&":     progW(i, OP_AND, 0);
                "|":     progW(i, OP_OR, 0);
                "~":     progW(i, OP_NOT, 0);
                default: progW(i, OP_TERM, int'(s[i] - 8'h61));
            endcase
        end
    endtask

    task automatic base(input logic [15:0] ty, input logic [7:0] b23);
        for (int i = 0; i < 64; i++) src.fr[i] = 8'h5A ^ 8'(i);
        src.fr[12] = ty[15:8];
        src.fr[13] = ty[7:0];
        src.fr[23] = b23;
    endtask

    // sends n bytes and checks the verdict exactly 3+steps cycles later
    task automatic run(input int n, input int steps, input logic disc);
        src.send(n);
        @(posedge clock);
        #1 chk(rxReady, 1'b0, "rxReady high while evaluating");
        repeat (steps + 2) @(posedge clock);
        #1;
        chk(decisionValid, 1'b1, "verdict not on time");
        chk(decisionDiscard, disc, "wrong verdict");
        chk(rxReady, 1'b1, "rxReady not back with verdict");
        #1;
    endtask

    // =================================================================
    // scenarios
    task automatic t_reset();
        chk(rxReady, 1'b1, "rxReady after reset");
        chk(decisionValid, 1'b0, "verdict after reset");
        chk(cfgRefused, 1'b0, "refusal after reset");
        base(16'h0800, 8'h06);
        run(30, 0, 1'b0);
    endtask

    task automatic t_type();
        term(0, 11'h00C, 5'h04, 64'h0800_0000_0000_0000, 64'hFFFF_0000_0000_0000);
        loadProg("a");
        base(16'h0800, 8'h06);
        run(30, 1, 1'b1);
        base(16'h0801, 8'h06);
        run(30, 1, 1'b0);
        base(16'h0800, 8'h06);
        run(13, 1, 1'b0);
        base(16'h0800, 8'h06);
        src.fr[0] = 8'h08;
        run(30, 1, 1'b1);
    endtask

    task automatic t_wild();
        term(0, 11'h00C, 5'h04, 64'h6000_0000_0000_0000, 64'hFFF0_0000_0000_0000);
        base(16'h6000, 8'h06);
        run(30, 1, 1'b1);
        base(16'h600F, 8'h06);
        run(30, 1, 1'b1);
        base(16'h6010, 8'h06);
        run(30, 1, 1'b0);
    endtask

    task automatic t_bits();
        term(0, 11'h000, 5'h02, 64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000);
        base(16'h0800, 8'h06);
        src.fr[0] = 8'h81;
        run(30, 1, 1'b1);
        src.fr[0] = 8'h7F;
        run(30, 1, 1'b0);
    endtask

    task automatic t_andNot();
        term(0, 11'h00C, 5'h04, 64'h0800_0000_0000_0000, 64'hFFFF_0000_0000_0000);
        term(1, 11'h017, 5'h02, 64'h0600_0000_0000_0000, 64'hFF00_0000_0000_0000);
        loadProg("ab~&");
        base(16'h0800, 8'h06);
        run(30, 4, 1'b0);
        base(16'h0800, 8'h11);
        run(30, 4, 1'b1);
        base(16'h86DD, 8'h11);
        run(30, 4, 1'b0);
    endtask

    task automatic t_group();
        term(0, 11'h00C, 5'h02, 64'h8000_0000_0000_0000, 64'hFF00_0000_0000_0000);
        term(1, 11'h00E, 5'h02, 64'h2400_0000_0000_0000, 64'hFF00_0000_0000_0000);
        term(2, 11'h00E, 5'h02, 64'h3200_0000_0000_0000, 64'hFF00_0000_0000_0000);
        loadProg("abc|&");
        base(16'h8000, 8'h06);
        src.fr[14] = 8'h32;
        run(30, 5, 1'b1);
        src.fr[14] = 8'h24;
        run(30, 5, 1'b1);
        src.fr[14] = 8'h33;
        run(30, 5, 1'b0);
        src.fr[12] = 8'h81;
        src.fr[14] = 8'h24;
        run(30, 5, 1'b0);
    endtask

    task automatic t_whole();
        term(0, 11'h00C, 5'h04, 64'h0800_0000_0000_0000, 64'hFFFF_0000_0000_0000);
        loadProg("a~");
        base(16'h0800, 8'h06);
        run(30, 2, 1'b0);
        base(16'h6004, 8'h06);
        run(30, 2, 1'b1);
        progW(2, OP_NOT, 0);
        chk(progRefused, 1'b1, "second negation taken");
        run(30, 2, 1'b1);
        filterEnable = 1'b0;
        run(30, 2, 1'b0);
        filterEnable = 1'b1;
    endtask

    // =================================================================
    // main sequence and watchdog
    initial
    begin
        fail_count    = 0;
        total_checks  = 0;
        rst           = 1'b1;
        filterEnable  = 1'b1;
        cfgTermWr     = 1'b0;
        cfgTermIdx    = 3'h0;
        cfgTermOffset = 11'h000;
        cfgTermLen    = 5'h00;
        cfgTermValue  = 64'h0;
        cfgTermCare   = 64'h0;
        cfgProgWr     = 1'b0;
        cfgProgIdx    = 4'h0;
        cfgProgOp     = OP_END;
        cfgProgArg    = 3'h0;
        repeat (6) @(posedge clock);
        #2 rst = 1'b0;
        t_reset();
        t_type();
        t_wild();
        t_bits();
        t_andNot();
        t_group();
        t_whole();
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule
